// ---- inc/adc_seq_consts.svh ----
/*
   Constants of the converter sequencer: widths, reset values and cycle counts.
   Assumes inclusion by bare name from the package and the sequencer module.
*/
`ifndef ADC_SEQ_CONSTS_SVH
`define ADC_SEQ_CONSTS_SVH

// ==========================================================================
// Widths
`define RESULT_W 12
`define TRIM_W 8
`define CHAN_W 5
`define CNT_W 12
`define SEL_W 4

// ==========================================================================
// Counts and reset values
`define CAL_CYCLES 3840
`define SAMPLE_CYCLES_DEF 4
`define TRIM_RESET 8'h80
`define TRIM_MAX 8'hff
`define TRIM_MIN 8'h00
`define MSB_INDEX 4'hb
`define LSB_INDEX 4'h0
`define POSTCAL_OFFSET 4'h0
`define POSTCAL_LAST 4'hc

`endif

// ---- inc/adc_seq_pkg.sv ----
/*
   Types of the converter sequencer: sequencing states and the state record.
   Assumes adc_seq_consts.svh is on the include path.
*/
`include "adc_seq_consts.svh"

package adc_seq_pkg;

   // ==========================================================================
   // Sequencing states
   typedef enum logic [2:0] {
      ST_CAL,
      ST_IDLE,
      ST_SAMPLE,
      ST_CONVERT,
      ST_POSTCAL
   } seq_state_e;

   // ==========================================================================
   // Whole state of the sequencer
   typedef struct packed {
      seq_state_e state;
      logic [`CNT_W-1:0] cnt;
      logic [`SEL_W-1:0] bit_idx;
      logic [`RESULT_W-1:0] code;
      logic [`RESULT_W-1:0] result;
      logic [`TRIM_W-1:0] trim;
      logic [`SEL_W-1:0] postcal_sel;
      logic [`CHAN_W-1:0] channel;
      logic calibrate;
      logic sample;
      logic busy;
      logic out_ready;
   } seq_s;

endpackage

// ---- verilog/adc_conversion_sequencer.sv ----
/*
   Control and handshake logic of a 12-bit successive-approximation converter:
   power-up calibration, start/channel handshake, sample/busy/result-valid
   sequencing, the SAR bit search and per-conversion trim of the calibration
   array. Assumes one clock that is also the converter clock, a comparator
   output from the analog core that is synchronous to it, and fabric logic that
   drives start pulses synchronously.
*/
// Summary of operation
// - After reset calibrate for 3,840 clock cycles
// - Eight-bit calibration array trims offset, linearity
// - Each conversion followed by one post-calibration step
// - Accepted start raises sample and busy
// - Sample drops after hold, busy stays high
// - Completion: busy low, valid high, result shown
// - Result-valid stays high until next start
// - Result-valid clears on a clock rising edge
// - Result held until next valid rising edge
`timescale 1ns/1ps
`include "adc_seq_consts.svh"

module adc_conversion_sequencer
   import adc_seq_pkg::*;
#(
   parameter int SAMPLE_CYCLES = `SAMPLE_CYCLES_DEF
)
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic convert_go_i,
   input wire logic [`CHAN_W-1:0] input_select_i,
   input wire logic comp_i,
   output logic calibrate_o,
   output logic sample_o,
   output logic busy_o,
   output logic out_ready_o,
   output logic [`RESULT_W-1:0] result_o,
   output logic [`CHAN_W-1:0] channel_o,
   output logic [`RESULT_W-1:0] dac_code_o,
   output logic [`TRIM_W-1:0] cal_trim_o,
   output logic [`SEL_W-1:0] postcal_sel_o
);

   // ==========================================================================
   // Helpers

   // One-hot trial weight for a SAR bit position
   function automatic logic [`RESULT_W-1:0] trial_bit(input logic [`SEL_W-1:0] idx);
      logic [`RESULT_W-1:0] w;
      w = '0;
      w[idx] = 1'b1;
      return w;
   endfunction

   // Saturating one-step move of the calibration trim; a high comparator
   // means the error is positive, so the trim steps down
   function automatic logic [`TRIM_W-1:0] trim_step(input logic [`TRIM_W-1:0] t,
                                                   input logic err_pos);
      logic [`TRIM_W-1:0] r;
      r = t;
      if (err_pos && t != `TRIM_MIN)
         r = t - `TRIM_W'(1);
      else if (!err_pos && t != `TRIM_MAX)
         r = t + `TRIM_W'(1);
      return r;
   endfunction

   // ==========================================================================
   // State record
   seq_s s_reg;
   seq_s s_next;
   logic accept;

   // Starts are honoured only in idle; pulses during calibration or a
   // conversion are dropped, which keeps a sloppy master from corrupting one
   assign accept = convert_go_i && (s_reg.state == ST_IDLE);

   // ==========================================================================
   // Next-state logic
   always_comb
   begin
      s_next = s_reg;
      unique case (s_reg.state)
         ST_CAL:
         begin
            s_next.trim = trim_step(s_reg.trim, comp_i);
            if (s_reg.cnt == '0)
            begin
               s_next.state = ST_IDLE;
               s_next.calibrate = 1'b0;
            end
            else
               s_next.cnt = s_reg.cnt - `CNT_W'(1);
         end
         ST_IDLE:
         begin
            if (accept)
            begin
               s_next.state = ST_SAMPLE;
               s_next.channel = input_select_i;
               s_next.sample = 1'b1;
               s_next.busy = 1'b1;
               s_next.out_ready = 1'b0;
               s_next.cnt = `CNT_W'(SAMPLE_CYCLES - 1);
            end
         end
         ST_SAMPLE:
         begin
            if (s_reg.cnt == '0)
            begin
               // Input is held; search starts at the MSB
               s_next.state = ST_CONVERT;
               s_next.sample = 1'b0;
               s_next.bit_idx = `MSB_INDEX;
               s_next.code = trial_bit(`MSB_INDEX);
            end
            else
               s_next.cnt = s_reg.cnt - `CNT_W'(1);
         end
         ST_CONVERT:
         begin
            // Drop the trial bit when the input lies below the trial level
            if (!comp_i)
               s_next.code = s_reg.code & ~trial_bit(s_reg.bit_idx);
            if (s_reg.bit_idx == `LSB_INDEX)
               s_next.state = ST_POSTCAL;
            else
            begin
               s_next.bit_idx = s_reg.bit_idx - `SEL_W'(1);
               s_next.code = (s_next.code) | trial_bit(s_reg.bit_idx - `SEL_W'(1));
            end
         end
         ST_POSTCAL:
         begin
            // One element per conversion, offset first, then each bit in turn
            s_next.trim = trim_step(s_reg.trim, comp_i);
            if (s_reg.postcal_sel == `POSTCAL_LAST)
               s_next.postcal_sel = `POSTCAL_OFFSET;
            else
               s_next.postcal_sel = s_reg.postcal_sel + `SEL_W'(1);
            s_next.state = ST_IDLE;
            s_next.busy = 1'b0;
            s_next.out_ready = 1'b1;
            s_next.result = s_reg.code;
         end
      endcase
   end

   // ==========================================================================
   // State register; reset restarts the power-up calibration
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         s_reg <= '0;
         s_reg.state <= ST_CAL;
         s_reg.cnt <= `CNT_W'(`CAL_CYCLES - 1);
         s_reg.calibrate <= 1'b1;
         s_reg.trim <= `TRIM_RESET;
      end
      else
         s_reg <= s_next;
   end

   // ==========================================================================
   // Outputs, all straight from the state register
   assign calibrate_o = s_reg.calibrate;
   assign sample_o = s_reg.sample;
   assign busy_o = s_reg.busy;
   assign out_ready_o = s_reg.out_ready;
   assign result_o = s_reg.result;
   assign channel_o = s_reg.channel;
   assign dac_code_o = s_reg.code;
   assign cal_trim_o = s_reg.trim;
   assign postcal_sel_o = s_reg.postcal_sel;

   // ==========================================================================
   // Checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);

   // Cycles from the fall of sample to the fall of busy: one per bit, plus post-cal
   localparam int CONV_TAIL = `RESULT_W + 1;

   // Counts calibrating cycles since reset release
   logic [`CNT_W:0] cal_seen;
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
         cal_seen <= '0;
      else if (calibrate_o)
         cal_seen <= cal_seen + (`CNT_W+1)'(1);
   end

   sequence s_conv_tail;
      busy_o && !sample_o ##CONV_TAIL $fell(busy_o);
   endsequence

   sequence s_finish;
      out_ready_o && !busy_o;
   endsequence

   property p_cal_len;
      $fell(calibrate_o) |-> cal_seen == (`CNT_W+1)'(`CAL_CYCLES);
   endproperty
   a_cal_len: assert property (p_cal_len) else $error("calibration length wrong");

   property p_trim_step;
      $changed(cal_trim_o) |-> $past(calibrate_o) || $past(s_reg.state == ST_POSTCAL);
   endproperty
   a_trim_step: assert property (p_trim_step) else $error("trim moved outside calibration");

   property p_postcal;
      $fell(busy_o) |-> $past(s_reg.state == ST_POSTCAL) && postcal_sel_o != $past(postcal_sel_o);
   endproperty
   a_postcal: assert property (p_postcal) else $error("conversion ended without post-calibration");

   property p_start;
      accept |=> sample_o && busy_o && channel_o == $past(input_select_i);
   endproperty
   a_start: assert property (p_start) else $error("start did not raise sample and busy");

   property p_hold;
      $fell(sample_o) |-> s_conv_tail;
   endproperty
   a_hold: assert property (p_hold) else $error("busy not held through conversion");

   property p_done;
      $fell(busy_o) |-> s_finish and result_o == $past(dac_code_o);
   endproperty
   a_done: assert property (p_done) else $error("completion outputs wrong");

   property p_valid_keep;
      out_ready_o && !convert_go_i |=> out_ready_o;
   endproperty
   a_valid_keep: assert property (p_valid_keep) else $error("result-valid dropped without start");

   property p_valid_clear;
      accept |=> !out_ready_o ##1 !out_ready_o;
   endproperty
   a_valid_clear: assert property (p_valid_clear) else $error("result-valid not cleared by start");

   property p_result_hold;
      $changed(result_o) |-> $rose(out_ready_o);
   endproperty
   a_result_hold: assert property (p_result_hold) else $error("result changed off valid edge");

endmodule

// ---- bench/analog_core_model.sv ----
/*
   Behavioural comparator of the analog converter core.
   Assumes the trial code is settled each cycle and the input level is static
   while a conversion runs.
*/
`timescale 1ns/1ps
`include "adc_seq_consts.svh"

module analog_core_model
(
   input wire logic [`RESULT_W-1:0] dac_code_i,
   input wire logic [`RESULT_W-1:0] level_i,
   output logic comp_o
);
   // ==========================================================================
   // Comparator
   // Ideal comparator: calibration sees no error correction from it, a known limit
   always_comb comp_o = (level_i >= dac_code_i);
endmodule

// ---- bench/tb.sv ----
/*
   Self-checking bench of the converter sequencer with an ideal analog core.
   Assumes the design's constants header is on the include path.
*/
`timescale 1ns/1ps
`include "adc_seq_consts.svh"

module tb;
   localparam int S = 2;
   logic clk_i = 0, reset_n_i = 0, convert_go_i = 0, comp_i;
   logic [4:0] input_select_i = 0;
   logic [11:0] level = 0;
   logic calibrate_o, sample_o, busy_o, out_ready_o;
   logic [11:0] result_o, dac_code_o;
   logic [4:0] channel_o;
   logic [7:0] cal_trim_o;
   logic [3:0] postcal_sel_o;
   logic [16:0] q[$];
   logic [16:0] e;
   logic rdy_prev = 0;
   int n_mismatch = 0, n_tests = 0, n, i;

   // ==========================================================================
   // Clock, design and partner
   always #20 clk_i = ~clk_i;
   adc_conversion_sequencer #(.SAMPLE_CYCLES(S)) adc_conversion_sequencer_i (.clk_i(clk_i),
      .reset_n_i(reset_n_i), .convert_go_i(convert_go_i), .input_select_i(input_select_i),
      .comp_i(comp_i), .calibrate_o(calibrate_o), .sample_o(sample_o), .busy_o(busy_o),
      .out_ready_o(out_ready_o), .result_o(result_o), .channel_o(channel_o),
      .dac_code_o(dac_code_o), .cal_trim_o(cal_trim_o), .postcal_sel_o(postcal_sel_o));
   analog_core_model analog_core_model_i (.dac_code_i(dac_code_o), .level_i(level), .comp_o(comp_i));

   // ==========================================================================
   // Checking and closing
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Monitor: each rising result-valid retires the oldest expected note, read while valid is high
   always @(negedge clk_i)
   begin
      if (out_ready_o === 1'b1 && rdy_prev !== 1'b1)
      begin
         if (q.size() == 0)
            chk(0, 1);
         else
         begin
            e = q.pop_front();
            chk({channel_o, result_o}, e);
         end
      end
      rdy_prev = out_ready_o;
   end

   // ==========================================================================
   // One conversion; poke retries a start while sampling, which must be ignored
   task automatic conv(input logic [4:0] ch, input logic [11:0] v, input bit poke);
      logic [3:0] sel;
      sel = postcal_sel_o;
      @(negedge clk_i);
      convert_go_i = 1;
      input_select_i = ch;
      level = v;
      q.push_back({ch, v});
      @(negedge clk_i);
      convert_go_i = poke;
      input_select_i = ~ch;
      chk(sample_o, 1);
      chk(busy_o, 1);
      chk(out_ready_o, 0);
      chk(channel_o, ch);
      n = 1;
      while (sample_o === 1'b1 && n < 50)
      begin
         @(negedge clk_i);
         convert_go_i = 0;
         n++;
      end
      chk(n, S + 1);
      chk(busy_o, 1);
      chk(dac_code_o, 12'h800);
      // No new start until busy has dropped
      while (busy_o === 1'b1 && n < 100)
      begin
         @(negedge clk_i);
         n++;
      end
      chk(n, S + 14);
      chk(postcal_sel_o, (sel == 4'hc) ? 4'h0 : sel + 4'h1);
   endtask

   // Waits out calibration, dropping one early start; no real start before it ends
   task automatic cal_wait();
      n = 0;
      while (calibrate_o === 1'b1 && n < 5000)
      begin
         @(negedge clk_i);
         n++;
         convert_go_i = (n == 100);
      end
      chk(n, 3840);
      chk({busy_o, out_ready_o}, 0);
      chk(cal_trim_o, 8'h00);
   endtask

   // ==========================================================================
   // Main sequence
   initial
   begin
      void'($urandom(18422));
      repeat (5) @(negedge clk_i);
      reset_n_i = 1;
      chk(calibrate_o, 1);
      chk(cal_trim_o, 8'h80);
      chk({busy_o, out_ready_o, sample_o}, 0);
      cal_wait();
      // Boundaries back to back, then random traffic with idle gaps
      conv(5'h00, 12'h000, 0);
      conv(5'h1f, 12'hfff, 1);
      for (i = 0; i < 16; i++)
      begin
         conv(5'($urandom), 12'($urandom), i[0]);
         repeat (3) @(negedge clk_i);
         chk(out_ready_o, 1);
         chk(result_o, level);
      end
      // Reset again while idle: calibration restarts from its reset values
      reset_n_i = 0;
      repeat (2) @(negedge clk_i);
      reset_n_i = 1;
      chk({calibrate_o, cal_trim_o, out_ready_o, postcal_sel_o}, {1'b1, 8'h80, 1'b0, 4'h0});
      cal_wait();
      conv(5'h0a, 12'h5a5, 0);
      repeat (2) @(negedge clk_i);
      end_of_test();
   end

   // Watchdog well beyond calibration plus all conversions
   initial
   begin
      #(40 * 20000);
      n_mismatch++;
      end_of_test();
   end
endmodule
